/* File: hw/rci_pkg.sv */
// constants shared by the radio coexistence interface block
// Summary of operation
// - receive activity mode 00 correlator only, 01 with power-up, 10 priority, 11 unused
// - transmit activity mode 00 without power-up, 01 with power-up, 10 priority, 11 invalid
// - external transmit input: 00 nothing, 01 stop tx, 10 stop rx, 11 both
// - external receive input: 00 nothing, 01 stop tx, 10 stop rx, 11 both
// - after reset external transmit ignored, external receive selected to stop local transmit only, once the enable bit is set
// - sync pulse only while sync enable bit is one; reset value zero
// - interface works only when enable bit is one; reset value zero
// - receive priority high when traffic indicator exceeds receive threshold in mode 10
// - transmit priority high when traffic indicator exceeds transmit threshold in mode 10
// - priority held for programmable microseconds, same for transmit and receive
// - hold time zero keeps priority until the enable falls
// - priority shown programmable microseconds before the enable rises
package rci_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_CTRL_MAIN = 32'h4000_0100;
  localparam logic [31:0] ADDR_PRIO_TIMING = 32'h4000_0104;
  localparam logic [31:0] ADDR_STATUS = 32'h4000_0180;

  // main control fields
  localparam int RX_MODE_LSB = 20;
  localparam int TX_MODE_LSB = 16;
  localparam int EXT_TX_SEL_LSB = 6;
  localparam int EXT_RX_SEL_LSB = 4;
  localparam int SYNC_EN_BIT = 1;
  localparam int COEXISTENCE_ENABLE_BIT = 0;
  localparam logic [31:0] CTRL_MAIN_MASK = 32'h0033_00f3;
  localparam logic [31:0] CTRL_MAIN_RESET = 32'h0000_0010;

  // priority timing fields
  localparam int RX_THR_LSB = 24;
  localparam int TX_THR_LSB = 16;
  localparam int HOLD_LSB = 8;
  localparam int LEAD_LSB = 0;
  localparam logic [31:0] PRIO_TIMING_MASK = 32'h1f1f_7f7f;
  localparam logic [31:0] PRIO_TIMING_RESET = 32'h0000_0000;

  // activity modes
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_PWRUP = 2'h1;
  localparam logic [1:0] MODE_PRIO = 2'h2;

  // timing: one microsecond in core clock cycles
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_US = 1000;
  localparam logic [7:0] US_CYC = 8'(NS_PER_US / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LEAD,
    ST_RUN
  } rci_state_t;
endpackage : rci_pkg

/* File: hw/rci_top.sv */
// radio coexistence interface: apb registers, wlan input sync, activity and priority shaping
module rci_top #(
  parameter int PTI_W = 4
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TX_REQ,
  input wire logic RX_REQ,
  input wire logic TX_PWRUP,
  input wire logic RX_PWRUP,
  input wire logic [PTI_W-1:0] PTI,
  input wire logic SYNC_EVT,
  input wire logic WLAN_TX,
  input wire logic WLAN_RX,
  output logic TX_GO,
  output logic RX_GO,
  output logic TX_STOP,
  output logic RX_STOP,
  output logic COEX_TX,
  output logic COEX_RX,
  output logic COEX_SYNC
);

  // the traffic indicator is compared against 5-bit thresholds
  if (PTI_W < 1 || PTI_W > 5)
  begin : g_chk
    $error("PTI_W must be 1 to 5");
  end

  // selects the activity level for one direction from its mode
  function automatic logic act_fn(input logic [1:0] mode, input logic run,
                                  input logic pwrup, input logic prio);
    unique case (mode)
      rci_pkg::MODE_PLAIN: act_fn = run;
      rci_pkg::MODE_PWRUP: act_fn = run | pwrup;
      rci_pkg::MODE_PRIO: act_fn = prio;
      default: act_fn = 1'b0;
    endcase
  endfunction : act_fn

  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] timing_r, timing_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [1:0] s1_r, s2_r, s3_r, wl_r, wl_nxt;
  logic tx_stop_r, tx_stop_nxt, rx_stop_r, rx_stop_nxt;
  logic ctx_r, ctx_nxt, crx_r, crx_nxt, csync_r, csync_nxt;
  logic coexistence_enable, sync_en;
  logic [1:0] mode [2];
  logic [1:0] ext_tx_sel, ext_rx_sel;
  logic [4:0] thr [2];
  logic [6:0] hold_us, lead_us;
  logic [1:0] req, pwrup, prio_mode, run_w, pon_w, hi_w;
  logic [6:0] us_w [2];
  logic setup, wr_en, mapped;
  logic [31:0] status;

  // field decode; index 0 is transmit, 1 is receive
  assign coexistence_enable = ctrl_r[rci_pkg::COEXISTENCE_ENABLE_BIT];
  assign sync_en = ctrl_r[rci_pkg::SYNC_EN_BIT];
  assign mode[0] = ctrl_r[rci_pkg::TX_MODE_LSB +: 2];
  assign mode[1] = ctrl_r[rci_pkg::RX_MODE_LSB +: 2];
  assign ext_tx_sel = ctrl_r[rci_pkg::EXT_TX_SEL_LSB +: 2];
  assign ext_rx_sel = ctrl_r[rci_pkg::EXT_RX_SEL_LSB +: 2];
  assign thr[0] = timing_r[rci_pkg::TX_THR_LSB +: 5];
  assign thr[1] = timing_r[rci_pkg::RX_THR_LSB +: 5];
  assign hold_us = timing_r[rci_pkg::HOLD_LSB +: 7];
  assign lead_us = timing_r[rci_pkg::LEAD_LSB +: 7];
  assign req = {RX_REQ, TX_REQ};
  assign pwrup = {RX_PWRUP, TX_PWRUP};

  // apb decode: zero wait states, unmapped access answers with an error
  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign mapped = (PADDR == rci_pkg::ADDR_CTRL_MAIN) || (PADDR == rci_pkg::ADDR_PRIO_TIMING)
                  || (PADDR == rci_pkg::ADDR_STATUS);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign PRDATA = prdata_r;
  assign status = {26'h000_0000, pon_w, run_w, wl_r};

  // three-stage sync of the wlan pins; a change counts once stages two and three agree
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      s3_r <= 2'h0;
    end
    else
    begin
      s1_r <= {WLAN_RX, WLAN_TX};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // next values of registers, filtered wlan levels and coexistence outputs
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    timing_nxt = timing_r;
    prdata_nxt = prdata_r;
    for (int i = 0; i < 2; i++)
    begin
      wl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : wl_r[i];
    end
    if (wr_en && PADDR == rci_pkg::ADDR_CTRL_MAIN)
    begin
      ctrl_nxt = PWDATA & rci_pkg::CTRL_MAIN_MASK;
    end
    if (wr_en && PADDR == rci_pkg::ADDR_PRIO_TIMING)
    begin
      timing_nxt = PWDATA & rci_pkg::PRIO_TIMING_MASK;
    end
    // read data is latched in the setup phase so it is a flop in the access phase
    if (setup && !PWRITE)
    begin
      unique case (PADDR)
        rci_pkg::ADDR_CTRL_MAIN: prdata_nxt = ctrl_r;
        rci_pkg::ADDR_PRIO_TIMING: prdata_nxt = timing_r;
        rci_pkg::ADDR_STATUS: prdata_nxt = status;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    // stop requests: low select bit stops transmit, high bit stops receive
    tx_stop_nxt = coexistence_enable & ((wl_r[0] & ext_tx_sel[0]) | (wl_r[1] & ext_rx_sel[0]));
    rx_stop_nxt = coexistence_enable & ((wl_r[0] & ext_tx_sel[1]) | (wl_r[1] & ext_rx_sel[1]));
    ctx_nxt = coexistence_enable & act_fn(mode[0], run_w[0], pwrup[0], hi_w[0]);
    crx_nxt = coexistence_enable & act_fn(mode[1], run_w[1], pwrup[1], hi_w[1]);
    csync_nxt = coexistence_enable & sync_en & SYNC_EVT;
  end

  // control registers reset to their documented values
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ctrl_r <= rci_pkg::CTRL_MAIN_RESET;
      timing_r <= rci_pkg::PRIO_TIMING_RESET;
      prdata_r <= 32'h0000_0000;
      wl_r <= 2'h0;
      tx_stop_r <= 1'b0;
      rx_stop_r <= 1'b0;
      ctx_r <= 1'b0;
      crx_r <= 1'b0;
      csync_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      timing_r <= timing_nxt;
      prdata_r <= prdata_nxt;
      wl_r <= wl_nxt;
      tx_stop_r <= tx_stop_nxt;
      rx_stop_r <= rx_stop_nxt;
      ctx_r <= ctx_nxt;
      crx_r <= crx_nxt;
      csync_r <= csync_nxt;
    end
  end

  assign TX_STOP = tx_stop_r;
  assign RX_STOP = rx_stop_r;
  assign COEX_TX = ctx_r;
  assign COEX_RX = crx_r;
  assign COEX_SYNC = csync_r;
  // the radio enable is withheld while the wlan side stops this direction
  assign TX_GO = run_w[0] & ~tx_stop_r;
  assign RX_GO = run_w[1] & ~rx_stop_r;

  // per direction: lead phase with priority shown, then run with priority held
  for (genvar d = 0; d < 2; d++)
  begin : g_dir
    rci_pkg::rci_state_t st_r, st_nxt;
    logic [7:0] cyc_r, cyc_nxt;
    logic [6:0] us_r, us_nxt;
    logic pon_r, pon_nxt;

    assign prio_mode[d] = coexistence_enable & (mode[d] == rci_pkg::MODE_PRIO);
    assign run_w[d] = (st_r == rci_pkg::ST_RUN);
    assign pon_w[d] = pon_r;
    assign us_w[d] = us_r;
    // threshold compare: strictly greater than
    assign hi_w[d] = pon_r & ({{(5 - PTI_W){1'b0}}, PTI} > thr[d]);

    // microsecond timer restarts at each state change; it saturates at the field maximum
    always_comb
    begin
      st_nxt = st_r;
      pon_nxt = pon_r;
      cyc_nxt = cyc_r + 8'h01;
      us_nxt = us_r;
      if (cyc_r == rci_pkg::US_CYC - 8'h01)
      begin
        cyc_nxt = 8'h00;
        if (us_r != 7'h7f)
        begin
          us_nxt = us_r + 7'h01;
        end
      end
      unique case (st_r)
        rci_pkg::ST_IDLE:
        begin
          pon_nxt = 1'b0;
          cyc_nxt = 8'h00;
          us_nxt = 7'h00;
          if (req[d])
          begin
            pon_nxt = prio_mode[d];
            st_nxt = prio_mode[d] ? rci_pkg::ST_LEAD : rci_pkg::ST_RUN;
          end
        end
        rci_pkg::ST_LEAD:
        begin
          if (!req[d])
          begin
            st_nxt = rci_pkg::ST_IDLE;
            pon_nxt = 1'b0;
          end
          else if (us_r == lead_us)
          begin
            st_nxt = rci_pkg::ST_RUN;
            cyc_nxt = 8'h00;
            us_nxt = 7'h00;
          end
        end
        rci_pkg::ST_RUN:
        begin
          if (!req[d])
          begin
            st_nxt = rci_pkg::ST_IDLE;
            pon_nxt = 1'b0;
          end
          else if (hold_us != 7'h00 && us_r == hold_us)
          begin
            pon_nxt = 1'b0;
          end
        end
        default:
        begin
          st_nxt = rci_pkg::ST_IDLE;
          pon_nxt = 1'b0;
        end
      endcase
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
      if (!RST_B)
      begin
        st_r <= rci_pkg::ST_IDLE;
        cyc_r <= 8'h00;
        us_r <= 7'h00;
        pon_r <= 1'b0;
      end
      else
      begin
        st_r <= st_nxt;
        cyc_r <= cyc_nxt;
        us_r <= us_nxt;
        pon_r <= pon_nxt;
      end
    end
  end

  // checks of the coexistence behaviour
  property p_disabled_quiet;
    @(posedge CLK) disable iff (!RST_B)
    !coexistence_enable |=> !COEX_TX && !COEX_RX && !COEX_SYNC && !TX_STOP && !RX_STOP;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("outputs active while disabled");

  property p_sync_gate;
    @(posedge CLK) disable iff (!RST_B)
    COEX_SYNC |-> $past(sync_en) && $past(SYNC_EVT);
  endproperty
  a_sync_gate: assert property (p_sync_gate) else $error("sync pulse without enable");

  property p_rx_pin_stops_tx;
    @(posedge CLK) disable iff (!RST_B)
    coexistence_enable && ext_rx_sel == 2'h1 && wl_r[1] && !(wl_r[0] && ext_tx_sel[1]) |=> TX_STOP && !RX_STOP;
  endproperty
  a_rx_pin_stops_tx: assert property (p_rx_pin_stops_tx) else $error("wlan rx effect wrong");

  property p_tx_pin_select;
    @(posedge CLK) disable iff (!RST_B)
    coexistence_enable && ext_tx_sel == 2'h2 && wl_r[0] && ext_rx_sel == 2'h0 |=> RX_STOP && !TX_STOP;
  endproperty
  a_tx_pin_select: assert property (p_tx_pin_select) else $error("wlan tx effect wrong");

  property p_rx_pwrup_mode;
    @(posedge CLK) disable iff (!RST_B)
    coexistence_enable && mode[1] == rci_pkg::MODE_PWRUP && RX_PWRUP |=> COEX_RX;
  endproperty
  a_rx_pwrup_mode: assert property (p_rx_pwrup_mode) else $error("rx power-up not shown");

  property p_tx_invalid_mode;
    @(posedge CLK) disable iff (!RST_B)
    mode[0] == 2'h3 |=> !COEX_TX;
  endproperty
  a_tx_invalid_mode: assert property (p_tx_invalid_mode) else $error("tx active in mode 11");

  property p_rx_prio_high;
    @(posedge CLK) disable iff (!RST_B)
    coexistence_enable && mode[1] == rci_pkg::MODE_PRIO && pon_w[1] && {1'b0, PTI} > thr[1] |=> COEX_RX;
  endproperty
  a_rx_prio_high: assert property (p_rx_prio_high) else $error("rx priority missing");

  property p_tx_prio_low;
    @(posedge CLK) disable iff (!RST_B)
    coexistence_enable && mode[0] == rci_pkg::MODE_PRIO && {1'b0, PTI} <= thr[0] |=> !COEX_TX;
  endproperty
  a_tx_prio_low: assert property (p_tx_prio_low) else $error("tx priority below threshold");

  property p_hold_expiry;
    @(posedge CLK) disable iff (!RST_B)
    run_w[0] && pon_w[0] && hold_us != 7'h00 && us_w[0] == hold_us |=> !pon_w[0];
  endproperty
  a_hold_expiry: assert property (p_hold_expiry) else $error("priority held too long");

  property p_hold_zero;
    @(posedge CLK) disable iff (!RST_B)
    run_w[1] && pon_w[1] && hold_us == 7'h00 && RX_REQ && $stable(timing_r) |=> pon_w[1];
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("priority dropped before enable");
  property p_lead_first;
    @(posedge CLK) disable iff (!RST_B)
    $rose(run_w[0]) && pon_w[0] |-> $past(g_dir[0].st_r == rci_pkg::ST_LEAD, 1);
  endproperty
  a_lead_first: assert property (p_lead_first) else $error("priority enable without lead");
endmodule : rci_top

/* File: tb/rci_wlan_model.sv */
// model of the collocated wlan arbiter driving the two request pins
module rci_wlan_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic want_tx,
  input wire logic want_rx,
  input wire logic [3:0] lag,
  output logic wlan_tx,
  output logic wlan_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // pins follow the wish lag+1 cycles later, so a slow arbiter is exercised as well
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= 4'h0;
      wlan_tx <= 1'b0;
      wlan_rx <= 1'b0;
    end
    else if ({want_tx, want_rx} == {wlan_tx, wlan_rx})
      cnt <= 4'h0;
    else if (cnt >= lag)
    begin
      wlan_tx <= want_tx;
      wlan_rx <= want_rx;
      cnt <= 4'h0;
    end
    else
      cnt <= cnt + 4'h1;
  end
endmodule : rci_wlan_model

/* File: tb/testbench.sv */
// self-checking bench for the radio coexistence interface
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] ctrl; logic wtx; logic wrx; logic stx; logic srx;} rci_row_t;
  logic CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [31:0] PADDR, PWDATA, PRDATA, rd;
  logic TX_REQ, RX_REQ, TX_PWRUP, RX_PWRUP, SYNC_EVT, WLAN_TX, WLAN_RX, want_tx, want_rx, err;
  logic TX_GO, RX_GO, TX_STOP, RX_STOP, COEX_TX, COEX_RX, COEX_SYNC;
  logic [3:0] PTI, lag;
  int n_mismatch = 0;
  int n_compared = 0;
  // effect table: control word, wlan pins, expected stops
  rci_row_t rows [9] = '{
    '{32'h0000_0011, 1'h1, 1'h0, 1'h0, 1'h0}, '{32'h0000_0011, 1'h0, 1'h1, 1'h1, 1'h0},
    '{32'h0000_0041, 1'h1, 1'h0, 1'h1, 1'h0}, '{32'h0000_0081, 1'h1, 1'h0, 1'h0, 1'h1},
    '{32'h0000_00c1, 1'h1, 1'h0, 1'h1, 1'h1}, '{32'h0000_0001, 1'h0, 1'h1, 1'h0, 1'h0},
    '{32'h0000_0021, 1'h0, 1'h1, 1'h0, 1'h1}, '{32'h0000_0031, 1'h0, 1'h1, 1'h1, 1'h1},
    '{32'h0000_0010, 1'h0, 1'h1, 1'h0, 1'h0}};

  rci_top dut_u (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TX_REQ(TX_REQ), .RX_REQ(RX_REQ), .TX_PWRUP(TX_PWRUP), .RX_PWRUP(RX_PWRUP), .PTI(PTI),
    .SYNC_EVT(SYNC_EVT), .WLAN_TX(WLAN_TX), .WLAN_RX(WLAN_RX), .TX_GO(TX_GO), .RX_GO(RX_GO),
    .TX_STOP(TX_STOP), .RX_STOP(RX_STOP), .COEX_TX(COEX_TX), .COEX_RX(COEX_RX),
    .COEX_SYNC(COEX_SYNC));
  rci_wlan_model wlan_u (.clk(CLK), .rst_b(RST_B), .want_tx(want_tx), .want_rx(want_rx),
    .lag(lag), .wlan_tx(WLAN_TX), .wlan_rx(WLAN_RX));

  always #2 CLK = ~CLK;

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; waits for pready with no assumed latency
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // emits one sync event and looks at the registered copy one edge later
  task automatic sync_try(input logic [31:0] c, input logic exp);
    apb(1'b1, rci_pkg::ADDR_CTRL_MAIN, c);
    cyc(2);
    SYNC_EVT <= 1'b1;
    @(posedge CLK);
    SYNC_EVT <= 1'b0;
    #1;
    chk({31'h0, COEX_SYNC}, {31'h0, exp});
  endtask : sync_try

  initial
  begin
    CLK = 1'b0;
    RST_B = 1'b0;
    {PSEL, PENABLE, PWRITE, TX_REQ, RX_REQ, TX_PWRUP, RX_PWRUP, SYNC_EVT} = 8'h00;
    {PADDR, PWDATA, PTI, lag, want_tx, want_rx} = 74'h0;
    cyc(16);
    RST_B <= 1'b1;
    apb(1'b0, rci_pkg::ADDR_CTRL_MAIN, 32'h0);
    chk(rd, 32'h0000_0010);
    apb(1'b0, rci_pkg::ADDR_PRIO_TIMING, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 32'h4000_0108, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, rci_pkg::ADDR_PRIO_TIMING, 32'hffff_ffff);
    apb(1'b0, rci_pkg::ADDR_PRIO_TIMING, 32'h0);
    chk(rd, 32'h1f1f_7f7f);
    $display("test registers done");
    // table of wlan effects, alternating a prompt and a slow arbiter
    foreach (rows[i])
    begin
      apb(1'b1, rci_pkg::ADDR_CTRL_MAIN, rows[i].ctrl);
      lag <= 4'(i % 2 * 3);
      want_tx <= rows[i].wtx;
      want_rx <= rows[i].wrx;
      cyc(12);
      chk({30'h0, TX_STOP, RX_STOP}, {30'h0, rows[i].stx, rows[i].srx});
      want_tx <= 1'b0;
      want_rx <= 1'b0;
      cyc(12);
    end
    $display("test wlan table done");
    sync_try(32'h0000_0013, 1'b1);
    sync_try(32'h0000_0011, 1'b0);
    sync_try(32'h0000_0002, 1'b0);
    $display("test sync done");
    apb(1'b1, rci_pkg::ADDR_PRIO_TIMING, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, rci_pkg::ADDR_CTRL_MAIN, 32'h11 | (m << 20) | (m << 16));
      TX_PWRUP <= 1'b1;
      RX_PWRUP <= 1'b1;
      cyc(4);
      chk({30'h0, COEX_TX, COEX_RX}, (m == 1) ? 32'h3 : 32'h0);
      TX_REQ <= 1'b1;
      RX_REQ <= 1'b1;
      cyc(4);
      chk({30'h0, COEX_TX, COEX_RX}, (m < 2) ? 32'h3 : 32'h0);
      {TX_REQ, RX_REQ, TX_PWRUP, RX_PWRUP} <= 4'h0;
      cyc(3);
    end
    $display("test modes done");
    // tx priority with one microsecond of lead and of hold
    apb(1'b1, rci_pkg::ADDR_PRIO_TIMING, 32'h0505_0101);
    apb(1'b1, rci_pkg::ADDR_CTRL_MAIN, 32'h0022_0011);
    PTI <= 4'h5;
    TX_REQ <= 1'b1;
    cyc(4);
    chk({31'h0, COEX_TX}, 32'h0);
    PTI <= 4'h6;
    cyc(3);
    chk({30'h0, COEX_TX, TX_GO}, 32'h2);
    cyc(200);
    chk({31'h0, TX_GO}, 32'h0);
    cyc(60);
    chk({31'h0, TX_GO}, 32'h1);
    // status shows the transmit run state and its priority flag still held
    apb(1'b0, rci_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0014);
    cyc(170);
    chk({31'h0, COEX_TX}, 32'h1);
    cyc(80);
    chk({31'h0, COEX_TX}, 32'h0);
    TX_REQ <= 1'b0;
    // rx priority with zero hold lasts while the request stands
    apb(1'b1, rci_pkg::ADDR_PRIO_TIMING, 32'h0300_0000);
    PTI <= 4'h3;
    RX_REQ <= 1'b1;
    cyc(4);
    chk({31'h0, COEX_RX}, 32'h0);
    PTI <= 4'h4;
    cyc(600);
    chk({30'h0, COEX_RX, RX_GO}, 32'h3);
    RX_REQ <= 1'b0;
    cyc(4);
    chk({30'h0, COEX_RX, RX_GO}, 32'h0);
    $display("test priority done");
    // reset in mid-run: a stopped radio first, then every radio and coexistence output falls and registers reload
    apb(1'b1, rci_pkg::ADDR_CTRL_MAIN, 32'h0033_00f3);
    want_rx <= 1'b1;
    TX_REQ <= 1'b1;
    cyc(12);
    chk({29'h0, TX_GO, TX_STOP, RX_STOP}, 32'h3);
    RST_B <= 1'b0;
    want_rx <= 1'b0;
    TX_REQ <= 1'b0;
    cyc(2);
    chk({25'h0, TX_GO, RX_GO, TX_STOP, RX_STOP, COEX_TX, COEX_RX, COEX_SYNC}, 32'h0);
    RST_B <= 1'b1;
    apb(1'b0, rci_pkg::ADDR_CTRL_MAIN, 32'h0);
    chk(rd, 32'h0000_0010);
    apb(1'b0, rci_pkg::ADDR_PRIO_TIMING, 32'h0);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
    close_out();
  end

  // watchdog well beyond the roughly 1500 cycles the sequence needs
  initial
  begin
    #80000;
    n_mismatch++;
    close_out();
  end
endmodule : testbench
